// ==== design/sdc_consts.vh ====
// Constants for the scaled difference comparator: register map, fields, limits.
`ifndef SDC_CONSTS_VH
`define SDC_CONSTS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SDC_REG_CTRL 8'h00
`define SDC_REG_GAIN 8'h04
`define SDC_REG_OFFSET 8'h08
`define SDC_REG_ON 8'h0C
`define SDC_REG_OFF 8'h10
`define SDC_REG_DECIMALS 8'h14
`define SDC_REG_STATUS 8'h18
`define SDC_REG_DIFF 8'h1C
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SDC_CTRL_ON_SEL_BIT 0
`define SDC_CTRL_OFF_SEL_BIT 1
`define SDC_CTRL_EVAL_BIT 2
`define SDC_CTRL_ON_BLK_LSB 8
`define SDC_CTRL_OFF_BLK_LSB 16
`define SDC_STAT_Q_BIT 0
`define SDC_STAT_VALID_BIT 1
`define SDC_DEC_W 2
`define SDC_GAIN_RST 32'h00000064
`define SDC_ZERO_RST 32'h00000000
// ----------------------------------------------------------------
// Limits, gain divisor and bus response codes (gain in hundredths)
// ----------------------------------------------------------------
`define SDC_GAIN_MAX 32'sd1000
`define SDC_GAIN_MIN -32'sd1000
`define SDC_OFS_MAX 32'sd10000
`define SDC_OFS_MIN -32'sd10000
`define SDC_THR_MAX 32'sd20000
`define SDC_THR_MIN -32'sd20000
`define SDC_GAIN_DIV 32'sd100
`define SDC_RESP_OKAY 2'b00
`define SDC_RESP_SLVERR 2'b10
`endif

// ==== design/sdc_eval.v ====
// One evaluation of the scaled difference comparator.
`timescale 1ns/1ns
`include "sdc_consts.vh"
module sdc_eval #(
   parameter IN_W = 16
) (
   // Operands
   input wire signed [IN_W-1:0] first_input,
   input wire signed [IN_W-1:0] second_input,
   input wire signed [31:0] gain,
   input wire signed [31:0] offset,
   input wire signed [31:0] on_level,
   input wire signed [31:0] off_level,
   input wire q_prev,
   // Results
   output reg q_next,
   output wire signed [31:0] diff
);
   // Clamp a value into a window.
   function signed [31:0] clamp;
      input signed [31:0] v;
      input signed [31:0] lo;
      input signed [31:0] hi;
      begin
         if (v < lo) begin
            clamp = lo;
         end else if (v > hi) begin
            clamp = hi;
         end else begin
            clamp = v;
         end
      end
   endfunction

   // Scale one input; gain is in hundredths, division truncates toward zero.
   function signed [31:0] scale;
      input signed [31:0] x;
      input signed [31:0] g;
      input signed [31:0] b;
      reg signed [31:0] p;
      begin
         p = x * g;
         scale = p / `SDC_GAIN_DIV + b;
      end
   endfunction

   wire signed [31:0] gain_c;
   wire signed [31:0] ofs_c;
   wire signed [31:0] work_x;
   wire signed [31:0] work_y;

   // Settings are clamped to their legal ranges.
   assign gain_c = clamp(gain, `SDC_GAIN_MIN, `SDC_GAIN_MAX);
   assign ofs_c = clamp(offset, `SDC_OFS_MIN, `SDC_OFS_MAX);
   // Same gain and offset for both inputs.
   assign work_x = scale({{(32-IN_W){first_input[IN_W-1]}}, first_input}, gain_c, ofs_c);
   assign work_y = scale({{(32-IN_W){second_input[IN_W-1]}}, second_input}, gain_c, ofs_c);
   // Plain integer compare; decimals never enter here.
   assign diff = work_x - work_y;

   // Threshold decision.
   always @* begin
      q_next = q_prev;
      if (on_level >= off_level) begin
         if (diff > on_level) begin
            q_next = 1'b1;
         end else if (diff <= off_level) begin
            q_next = 1'b0;
         end else begin
            q_next = q_prev;
         end
      end else begin
         q_next = (diff >= on_level) && (diff < off_level);
      end
   end
endmodule

// ==== design/sdc_top.v ====
// Scaled difference comparator with AXI4-Lite register access.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "sdc_consts.vh"
module sdc_top #(
   parameter IN_W = 16,
   parameter NBLK = 8
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Analog operands
   input wire [IN_W-1:0] first_input,
   input wire [IN_W-1:0] second_input,
   // Live values of other blocks, NBLK words of 32 bits
   input wire [NBLK*32-1:0] blk_values,
   // Comparator output
   output reg q_out,
   // AXI4-Lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg [31:0] ctrl_q;
   reg [31:0] gain_q;
   reg [31:0] ofs_q;
   reg [31:0] on_q;
   reg [31:0] off_q;
   reg [`SDC_DEC_W-1:0] dec_q;
   reg valid_q;
   reg [31:0] diff_q;
   reg [7:0] awaddr_q;
   reg aw_have_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg w_have_q;

   wire signed [31:0] diff_w;
   wire q_next_w;
   wire signed [31:0] on_lvl;
   wire signed [31:0] off_lvl;
   wire [7:0] on_idx;
   wire [7:0] off_idx;

   // Byte-lane merge for a register write.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] st;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (st[i]) begin
               merge[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction

   // Pick a live value by block number; out of range reads zero.
   function [31:0] pick;
      input [NBLK*32-1:0] vals;
      input [7:0] idx;
      begin
         if (idx < NBLK) begin
            pick = vals[idx*32 +: 32];
         end else begin
            pick = 32'h00000000;
         end
      end
   endfunction

   // Clamp a threshold into its legal window.
   function [31:0] thr_clamp;
      input signed [31:0] v;
      begin
         if (v > `SDC_THR_MAX) begin
            thr_clamp = `SDC_THR_MAX;
         end else if (v < `SDC_THR_MIN) begin
            thr_clamp = `SDC_THR_MIN;
         end else begin
            thr_clamp = v;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // Threshold sources and evaluation
   // ----------------------------------------------------------------
   assign on_idx = ctrl_q[`SDC_CTRL_ON_BLK_LSB +: 8];
   assign off_idx = ctrl_q[`SDC_CTRL_OFF_BLK_LSB +: 8];
   // Either threshold may be a constant or another block's value.
   assign on_lvl = thr_clamp(ctrl_q[`SDC_CTRL_ON_SEL_BIT] ? pick(blk_values, on_idx)
                             : on_q);
   assign off_lvl = thr_clamp(ctrl_q[`SDC_CTRL_OFF_SEL_BIT] ? pick(blk_values, off_idx)
                              : off_q);

   sdc_eval #(
      .IN_W(IN_W)
   ) u_eval (
      .first_input(first_input),
      .second_input(second_input),
      .gain(gain_q),
      .offset(ofs_q),
      .on_level(on_lvl),
      .off_level(off_lvl),
      .q_prev(q_out),
      .q_next(q_next_w),
      .diff(diff_w)
   );

   // One evaluation per clock once enabled; output low until then.
   // Pulse filtering is left to a delay stage downstream, keeping this path short.
   always @(posedge aclk) begin
      if (!aresetn) begin
         q_out <= 1'b0;
         valid_q <= 1'b0;
         diff_q <= `SDC_ZERO_RST;
      end else if (ctrl_q[`SDC_CTRL_EVAL_BIT]) begin
         q_out <= q_next_w;
         valid_q <= 1'b1;
         diff_q <= diff_w;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------
   // Address and data are latched independently; the write fires once both are held.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SDC_RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         ctrl_q <= `SDC_ZERO_RST;
         gain_q <= `SDC_GAIN_RST;
         ofs_q <= `SDC_ZERO_RST;
         on_q <= `SDC_ZERO_RST;
         off_q <= `SDC_ZERO_RST;
         dec_q <= {`SDC_DEC_W{1'b0}};
      end else begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
         s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (aw_have_q && w_have_q && !s_axi_bvalid) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `SDC_RESP_OKAY;
            // Byte lanes below the word are ignored, so the decode sees whole words.
            case ({awaddr_q[7:2], 2'b00})
               `SDC_REG_CTRL: begin
                  ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
               end
               `SDC_REG_GAIN: begin
                  gain_q <= merge(gain_q, wdata_q, wstrb_q);
               end
               `SDC_REG_OFFSET: begin
                  ofs_q <= merge(ofs_q, wdata_q, wstrb_q);
               end
               `SDC_REG_ON: begin
                  on_q <= merge(on_q, wdata_q, wstrb_q);
               end
               `SDC_REG_OFF: begin
                  off_q <= merge(off_q, wdata_q, wstrb_q);
               end
               `SDC_REG_DECIMALS: begin
                  if (wstrb_q[0]) begin
                     dec_q <= wdata_q[`SDC_DEC_W-1:0];
                  end
               end
               `SDC_REG_STATUS, `SDC_REG_DIFF: begin
                  s_axi_bresp <= `SDC_RESP_OKAY;
               end
               default: begin
                  s_axi_bresp <= `SDC_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------
   // Reads answer one cycle after the address is taken.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SDC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `SDC_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
               `SDC_REG_CTRL: s_axi_rdata <= ctrl_q;
               `SDC_REG_GAIN: s_axi_rdata <= gain_q;
               `SDC_REG_OFFSET: s_axi_rdata <= ofs_q;
               `SDC_REG_ON: s_axi_rdata <= on_q;
               `SDC_REG_OFF: s_axi_rdata <= off_q;
               `SDC_REG_DECIMALS: s_axi_rdata <= {30'h0, dec_q};
               `SDC_REG_STATUS: s_axi_rdata <= {30'h0, valid_q, q_out};
               `SDC_REG_DIFF: s_axi_rdata <= diff_q;
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `SDC_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// ==== test/sdc_monitor.sv ====
// Port-level checker of bus timing and reset behaviour of the comparator.
`timescale 1ns/1ns
module sdc_monitor #(
   parameter IN_W = 16,
   parameter NBLK = 8
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Operands and output
   input wire [IN_W-1:0] first_input,
   input wire [IN_W-1:0] second_input,
   input wire [NBLK*32-1:0] blk_values,
   input wire q_out,
   // Write channels
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   // Read channels
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // The reset check ignores the disable, since it looks at reset itself.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_q_reset_low: assert property (disable iff (1'b0) !aresetn |=> !q_out)
      else $error("q_out high after reset");
   a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready longer than one cycle");
   a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
      else $error("wready longer than one cycle");
   a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write response late");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while response pending");
endmodule
bind sdc_top sdc_monitor #(.IN_W(IN_W), .NBLK(NBLK)) u_mon (.*);

// ==== test/sdc_tb.sv ====
// Self-checking bench for the scaled difference comparator.
`timescale 1ns/1ns
`include "sdc_consts.vh"
module testbench;
   // ------------------------------------------------------------
   // Signals and helpers
   // ------------------------------------------------------------
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [15:0] first_input = 0, second_input = 0;
   logic [255:0] blk = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rd_d, rnd = 32'hBF74;
   logic [1:0] rd_r, wr_r;
   logic [3:0] wstrb = 4'hF;
   wire q_out, awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int error_cnt = 0, checked = 0, cyc = 0;
   sdc_top DUT (.aclk(aclk), .aresetn(aresetn), .first_input(first_input),
      .second_input(second_input), .blk_values(blk), .q_out(q_out), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   always #25 aclk = ~aclk;
   function automatic int rv(input int n);
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      return int'(rnd % n);
   endfunction
   function automatic int cl(input int v, input int l);
      return v > l ? l : (v < -l ? -l : v);
   endfunction
   // Expected output from the difference, both levels and the last output.
   function automatic logic mq(input int d, input int on, input int off, input logic p);
      if (on >= off) return d > on ? 1'b1 : (d <= off ? 1'b0 : p);
      return d >= on && d < off;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Each channel is released at the edge its ready is seen; the answer is taken there too.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      bready <= 0;
      wr_r = bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      rready <= 0;
      rd_d = rdata;
      rd_r = rresp;
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // A hang ends the run as a mismatch.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         stop_test();
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      int t, k, x, y, g, o, onc, ofc, on, off, d, dec, i1, i2;
      int bv[8];
      logic [1:0] sel;
      logic qm;
      qm = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      #1 chk("q after reset", 0, q_out);
      rd(`SDC_REG_GAIN);
      chk("gain reset", `SDC_GAIN_RST, rd_d);
      rd(8'h20);
      chk("unmapped resp", `SDC_RESP_SLVERR, rd_r);
      chk("unmapped data", 0, rd_d);
      rd(`SDC_REG_STATUS);
      chk("valid after reset", 0, rd_d[1]);
      wr(8'h20, 0);
      chk("unmapped write resp", `SDC_RESP_SLVERR, wr_r);
      // Only lane 0 is enabled, so the upper bytes of the reset gain must survive.
      wstrb <= 4'h1;
      wr(`SDC_REG_GAIN, 32'h12345678);
      wstrb <= 4'hF;
      rd(`SDC_REG_GAIN);
      chk("gain lane 0", 32'h00000078, rd_d);
      $display("reset test done");
      // Random settings; some thresholds sit on the difference or come from blocks.
      for (t = 0; t < 60; t++) begin
         x = rv(6001) - 3000;
         y = rv(6001) - 3000;
         g = rv(2401) - 1200;
         o = rv(22001) - 11000;
         sel = rv(4);
         i1 = rv(9);
         i2 = rv(9);
         dec = rv(4);
         for (k = 0; k < 8; k++) bv[k] = rv(60001) - 30000;
         d = (x * cl(g, 1000) / 100 + cl(o, 10000)) - (y * cl(g, 1000) / 100 + cl(o, 10000));
         onc = t % 3 == 0 ? d + rv(3) - 1 : rv(50001) - 25000;
         ofc = t % 3 == 1 ? d + rv(3) - 1 : rv(50001) - 25000;
         on = sel[0] ? (i1 < 8 ? cl(bv[i1], 20000) : 0) : cl(onc, 20000);
         off = sel[1] ? (i2 < 8 ? cl(bv[i2], 20000) : 0) : cl(ofc, 20000);
         wr(`SDC_REG_CTRL, 0);
         wr(`SDC_REG_GAIN, g);
         wr(`SDC_REG_OFFSET, o);
         wr(`SDC_REG_ON, onc);
         wr(`SDC_REG_OFF, ofc);
         wr(`SDC_REG_DECIMALS, dec);
         first_input <= x[15:0];
         second_input <= y[15:0];
         for (k = 0; k < 8; k++) blk[32*k +: 32] <= bv[k];
         wr(`SDC_REG_CTRL, {8'h00, i2[7:0], i1[7:0], 8'h04 | 8'(sel)});
         chk("write resp", `SDC_RESP_OKAY, wr_r);
         repeat (3) @(posedge aclk);
         qm = mq(d, on, off, qm);
         // The output is compared raw; pulse suppression belongs to a delay stage downstream.
         #1 chk("q", qm, q_out);
         rd(`SDC_REG_DIFF);
         chk("diff", d, rd_d);
         rd(`SDC_REG_STATUS);
         chk("status q", qm, rd_d[0]);
         chk("status valid", 1, rd_d[1]);
         // The register keeps the written word; the limit applies where the gain is used.
         rd(`SDC_REG_GAIN);
         chk("gain", g, rd_d);
         rd(`SDC_REG_DECIMALS);
         chk("decimals", dec, rd_d[1:0]);
      end
      $display("compare test done");
      @(posedge aclk);
      aresetn <= 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      #1 chk("q after second reset", 0, q_out);
      rd(`SDC_REG_GAIN);
      chk("gain second reset", `SDC_GAIN_RST, rd_d);
      rd(`SDC_REG_STATUS);
      chk("valid second reset", 0, rd_d[1]);
      $display("second reset test done");
      stop_test();
   end
endmodule
